// *** hw/pcd_pkg.sv ***
package pcd_pkg;

    // ----------------------------------------
    // Clock and timing figures
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SETTLE_PS = 1600;
    localparam int STOP_PS = 700;
    localparam int SETUP_PS = 20000;
    // Least times round up, longest times round down, never below one cycle
    localparam int SETTLE_CYC_RAW = (SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int STOP_CYC_RAW = STOP_PS / CLK_PERIOD_PS;
    localparam int STOP_CYC = (STOP_CYC_RAW < 1) ? 1 : STOP_CYC_RAW;
    localparam int SETUP_CYC = (SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------
    // Sequencing counts in input clock periods
    // ----------------------------------------
    localparam int PEND_BASE_CYC = 64;
    localparam logic [7:0] PEND_CYC = 8'(PEND_BASE_CYC + SETTLE_CYC);
    localparam logic [7:0] RESUME_CYC = 8'(PEND_BASE_CYC + SETTLE_CYC);
    localparam logic [7:0] IDLE_CYC = 8'hC0;

    // ----------------------------------------
    // Ratio encoding and reset values
    // ----------------------------------------
    localparam logic [7:0] SEL_ZERO = 8'h00;
    localparam logic [8:0] RATIO_MAX = 9'h100;
    localparam logic [8:0] RATIO_ONE = 9'h001;
    localparam logic [7:0] SEL_RST = 8'h00;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_PENDING,
        ST_IDLE,
        ST_HOLD,
        ST_RESUME
    } pcd_state_t;

endpackage

// *** hw/pcd_div_core.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcd_div_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Control
    input wire logic run,
    input wire logic [8:0] ratio,
    // Divided clock
    output logic clk_out
);

    logic [7:0] cnt;
    logic pos_q;
    logic neg_q;
    logic [8:0] hi_cyc;
    logic wrap;

    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    // High phase length, rounded up for odd ratios
    assign hi_cyc = {1'b0, ratio[8:1]} + {8'h00, ratio[0]};
    assign wrap = ({1'b0, cnt} == (ratio - pcd_pkg::RATIO_ONE));

    // Count 0..ratio-1, parked at zero while stopped
    always_ff @(posedge mclk) begin
        if (!rst_b || !run) begin
            cnt <= 8'h00;
        end else if (wrap) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Rising-edge phase flop
    always_ff @(posedge mclk) begin
        if (!rst_b || !run) begin
            pos_q <= 1'b0;
        end else begin
            pos_q <= ({1'b0, cnt} < hi_cyc);
        end
    end

    // Half-cycle delayed copy trims odd ratios to half high
    always_ff @(negedge mclk) begin
        if (!rst_b) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= pos_q;
        end
    end

    // ----------------------------------------
    // Output select
    // ----------------------------------------
    // Ratio one passes the clock, odd ratios overlap both phases
    always_comb begin
        if (ratio == pcd_pkg::RATIO_ONE) begin
            clk_out = pos_q & mclk;
        end else if (ratio[0]) begin
            clk_out = pos_q & neg_q;
        end else begin
            clk_out = pos_q;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_count_bound: assert property (@(posedge mclk) disable iff (!rst_b)
        {1'b0, cnt} < ratio) else $error("divider count beyond ratio");

    a_high_phase: assert property (@(posedge mclk) disable iff (!rst_b)
        run && $past(run) && ($past({1'b0, cnt}) < $past(hi_cyc)) |-> pos_q)
        else $error("high phase shorter than half period");

    a_low_phase: assert property (@(posedge mclk) disable iff (!rst_b)
        run && $past(run) && ($past({1'b0, cnt}) >= $past(hi_cyc)) |-> !pos_q)
        else $error("high phase longer than half period");

endmodule

`default_nettype wire

// *** hw/pcd_divider.sv ***
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - A nonzero select code 1..255 is taken as an unsigned value, bit 7 highest, and sets that division ratio.
// - An all-zero select code divides by 256.
// - The divided clock is high for half its period for every ratio, odd or even.
// - After any select change the divider goes idle 64 to 128 periods plus 1.6 ns later.
// - From idle it waits another 192 periods and then runs with the new ratio.
// - The divider resets its own state at power-up and on every select change.
// - External reset high stops dividing within three cycles, after its two-stage synchroniser, and holds the output low.
// - After external reset falls the divider runs again 64 to 128 periods plus 1.6 ns later.
// - The select may change while the clock runs, with about 20 ns set-up.
module pcd_divider (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Controller pins
    input wire logic [7:0] ratio_select_bits,
    input wire logic ext_reset,
    // Divided clock and status
    output logic div_clk_out,
    output logic div_idle
);

    logic [7:0] sel_s1;
    logic [7:0] sel_s2;
    logic [7:0] sel_prev;
    logic rst_s1;
    logic rst_s2;
    logic sel_change;
    pcd_pkg::pcd_state_t state;
    logic [7:0] cnt;
    logic [8:0] ratio;
    logic run;
    logic [7:0] resume_len;

    // Select code to ratio, zero meaning the largest ratio
    function automatic logic [8:0] ratio_of(input logic [7:0] sel);
        if (sel == pcd_pkg::SEL_ZERO) begin
            ratio_of = pcd_pkg::RATIO_MAX;
        end else begin
            ratio_of = {1'b0, sel};
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two stages for the select lines, plus the last seen code
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sel_s1 <= pcd_pkg::SEL_RST;
            sel_s2 <= pcd_pkg::SEL_RST;
            sel_prev <= pcd_pkg::SEL_RST;
        end else begin
            sel_s1 <= ratio_select_bits;
            sel_s2 <= sel_s1;
            sel_prev <= sel_s2;
        end
    end

    // Two stages for the external reset
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= ext_reset;
            rst_s2 <= rst_s1;
        end
    end

    assign sel_change = (sel_s2 != sel_prev);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // State and interval counter; external reset outranks a select change
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= pcd_pkg::ST_RESUME;
            cnt <= 8'h00;
        end else if (rst_s2) begin
            state <= pcd_pkg::ST_HOLD;
            cnt <= 8'h00;
        end else if (sel_change && state != pcd_pkg::ST_HOLD) begin
            state <= pcd_pkg::ST_PENDING;
            cnt <= 8'h00;
        end else begin
            unique case (state)
                pcd_pkg::ST_RUN: begin
                    cnt <= 8'h00;
                end
                pcd_pkg::ST_PENDING: begin
                    if (cnt == pcd_pkg::PEND_CYC - 8'h01) begin
                        state <= pcd_pkg::ST_IDLE;
                        cnt <= 8'h00;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                pcd_pkg::ST_IDLE: begin
                    if (cnt == pcd_pkg::IDLE_CYC - 8'h01) begin
                        state <= pcd_pkg::ST_RUN;
                        cnt <= 8'h00;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                pcd_pkg::ST_HOLD: begin
                    state <= pcd_pkg::ST_RESUME;
                    cnt <= 8'h00;
                end
                pcd_pkg::ST_RESUME: begin
                    if (cnt == pcd_pkg::RESUME_CYC - 8'h01) begin
                        state <= pcd_pkg::ST_RUN;
                        cnt <= 8'h00;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    // Ratio taken fresh each time an idle or resume interval ends
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ratio <= pcd_pkg::RATIO_MAX;
        end else if ((state == pcd_pkg::ST_IDLE && cnt == pcd_pkg::IDLE_CYC - 8'h01)
                     || (state == pcd_pkg::ST_RESUME && cnt == pcd_pkg::RESUME_CYC - 8'h01)) begin
            ratio <= ratio_of(sel_s2);
        end
    end

    // ----------------------------------------
    // Divider core and status
    // ----------------------------------------
    // Output keeps running until the pending interval ends
    assign run = (state == pcd_pkg::ST_RUN || state == pcd_pkg::ST_PENDING) && !rst_s2;

    pcd_div_core u_core (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(run),
        .ratio(ratio),
        .clk_out(div_clk_out)
    );

    // Idle flag from the sequencer state
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_idle <= 1'b1;
        end else begin
            div_idle <= !run;
        end
    end

    // Resume interval length, counted apart from the sequencer counter
    always_ff @(posedge mclk) begin
        if (!rst_b || state != pcd_pkg::ST_RESUME) begin
            resume_len <= 8'h00;
        end else begin
            resume_len <= resume_len + 8'h01;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_pend_done;
        state == pcd_pkg::ST_PENDING && cnt == pcd_pkg::PEND_CYC - 8'h01 && !rst_s2 && !sel_change;
    endsequence

    sequence s_idle_done;
        state == pcd_pkg::ST_IDLE && cnt == pcd_pkg::IDLE_CYC - 8'h01 && !rst_s2 && !sel_change;
    endsequence

    a_ratio_load: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(state == pcd_pkg::ST_RUN) |-> ratio == ratio_of($past(sel_s2)))
        else $error("ratio not taken from select code");

    a_zero_code: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(state == pcd_pkg::ST_RUN) && $past(sel_s2) == pcd_pkg::SEL_ZERO |-> ratio == pcd_pkg::RATIO_MAX)
        else $error("zero code not dividing by 256");

    a_change_pending: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_change && !rst_s2 && state != pcd_pkg::ST_HOLD |=> state == pcd_pkg::ST_PENDING && cnt == 8'h00)
        else $error("select change not starting pending interval");

    a_pend_to_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        s_pend_done |=> state == pcd_pkg::ST_IDLE ##1 div_idle)
        else $error("pending interval not ending in idle");

    a_idle_to_run: assert property (@(posedge mclk) disable iff (!rst_b)
        s_idle_done |=> state == pcd_pkg::ST_RUN ##1 !div_idle)
        else $error("idle interval not ending in run");

    a_idle_low: assert property (@(posedge mclk) disable iff (!rst_b)
        state == pcd_pkg::ST_IDLE && $past(state) == pcd_pkg::ST_IDLE |-> !div_clk_out)
        else $error("output not low while idle");

    a_resume_low: assert property (@(posedge mclk) disable iff (!rst_b)
        state == pcd_pkg::ST_RESUME && $past(state) == pcd_pkg::ST_RESUME |-> !div_clk_out)
        else $error("output not low while resuming");

    a_reset_stop: assert property (@(posedge mclk) disable iff (!rst_b)
        rst_s2 |=> !run ##1 (!div_clk_out)[*2])
        else $error("external reset did not stop output");

    a_resume_len: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(state == pcd_pkg::ST_RUN) && $past(state) == pcd_pkg::ST_RESUME
        |-> $past(resume_len) == pcd_pkg::RESUME_CYC - 8'h01)
        else $error("resume interval wrong length");

    a_self_reset: assert property (@(posedge mclk)
        !rst_b |=> state == pcd_pkg::ST_RESUME && cnt == 8'h00 && div_idle)
        else $error("power-up reset did not restart sequencer");

endmodule

`default_nettype wire

// *** verif/pcd_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcd_ctrl_model (
    // Clock
    input wire logic mclk,
    // Commands from the bench
    input wire logic [7:0] cmd_sel,
    input wire logic cmd_rst,
    // Controller pins
    output logic [7:0] ratio_select_bits,
    output logic ext_reset
);
    int hold_cnt = 0;

    initial begin
        ratio_select_bits = 8'h00;
        ext_reset = 1'b0;
    end

    // Select pins move a fixed delay after the edge and stay put
    always @(posedge mclk) begin
        ratio_select_bits <= #1 cmd_sel;
    end

    // Reset is never let go before 65 cycles high
    always @(posedge mclk) begin
        if (cmd_rst) begin
            ext_reset <= #1 1'b1;
        end else if (hold_cnt >= 65) begin
            ext_reset <= #1 1'b0;
        end
        hold_cnt <= ext_reset ? hold_cnt + 1 : 0;
    end
endmodule

`default_nettype wire

// *** verif/programmable_integer_clock_divider_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module programmable_integer_clock_divider_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] cmd_sel = 8'h00;
    logic cmd_rst = 1'b0;
    logic [7:0] sel_pins;
    logic ext_rst_pin;
    logic div_clk_out;
    logic div_idle;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    logic hi;

    // Design and controller model
    pcd_divider i_dut (.mclk(mclk), .rst_b(rst_b), .ratio_select_bits(sel_pins), .ext_reset(ext_rst_pin),
        .div_clk_out(div_clk_out), .div_idle(div_idle));
    pcd_ctrl_model i_ctrl (.mclk(mclk), .cmd_sel(cmd_sel), .cmd_rst(cmd_rst), .ratio_select_bits(sel_pins),
        .ext_reset(ext_rst_pin));

    // 125 MHz clock
    always #4 mclk = ~mclk;

    // Cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Counts cycles until idle flag equals val; notes output high while idle
    task automatic wait_idle(input logic val, output int cnt, output logic high_seen);
        cnt = 0;
        high_seen = 1'b0;
        while (div_idle !== val && cnt < 1000) begin
            @(posedge mclk);
            #1;
            cnt++;
            if (div_idle === 1'b1 && div_clk_out !== 1'b0) begin
                high_seen = 1'b1;
            end
        end
    endtask

    // Period and high time of a settled divided clock
    task automatic measure(input int ratio);
        time t0;
        time t1;
        time t2;
        @(posedge div_clk_out);
        @(posedge div_clk_out);
        t0 = $time;
        @(negedge div_clk_out);
        t1 = $time;
        @(posedge div_clk_out);
        t2 = $time;
        check(32'(t2 - t0), 32'(ratio * 8));
        check(32'(t1 - t0), 32'(ratio * 4));
    endtask

    // Select change: idle entry window, idle length, output low
    task automatic sel_change(input logic [7:0] v);
        @(posedge mclk);
        #1;
        cmd_sel = v;
        @(posedge mclk);
        #2;
        wait_idle(1'b1, n, hi);
        check(32'(n >= 65 && n <= 131), 32'h1);
        wait_idle(1'b0, n, hi);
        check(32'(n), 32'h0C0);
        check(32'(hi), 32'h0);
        measure(v == 8'h00 ? 256 : int'(v));
    endtask

    // Second change in mid-pending restarts the sequence
    task automatic restart_case();
        @(posedge mclk);
        #1;
        cmd_sel = 8'h05;
        repeat (30) @(posedge mclk);
        #1;
        cmd_sel = 8'h04;
        @(posedge mclk);
        #2;
        wait_idle(1'b1, n, hi);
        check(32'(n >= 65 && n <= 131), 32'h1);
        wait_idle(1'b0, n, hi);
        measure(4);
    endtask

    // External reset: output held low, then resumes
    task automatic ext_reset_case();
        @(posedge mclk);
        #1;
        cmd_rst = 1'b1;
        @(posedge ext_rst_pin);
        repeat (4) @(posedge mclk);
        hi = 1'b0;
        repeat (60) begin
            @(posedge mclk);
            #1;
            if (div_clk_out !== 1'b0) begin
                hi = 1'b1;
            end
        end
        check(32'(hi), 32'h0);
        cmd_rst = 1'b0;
        @(negedge ext_rst_pin);
        wait_idle(1'b0, n, hi);
        check(32'(n >= 65 && n <= 131), 32'h1);
        measure(4);
    endtask

    // Main sequence
    initial begin
        logic [7:0] ratios [7];
        ratios = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h80, 8'hFF, 8'h00};
        repeat (4) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        wait_idle(1'b0, n, hi);
        check(32'(n >= 65 && n <= 131), 32'h1);
        foreach (ratios[i]) begin
            sel_change(ratios[i]);
        end
        restart_case();
        ext_reset_case();
        complete_run();
    end
endmodule

`default_nettype wire
